// ### design/cet_exec_timing.sv
/*
 * cet_exec_timing: sequences the states of one instruction through the
 * six cycle kinds and reports the total and the running count of states.
 * Assumes start is a one-cycle request made only while busy is low, and
 * that the peripheral wait class is known when the instruction starts.
 */
`timescale 1ns/1ps
module cet_exec_timing
(
    // clock and reset
    input  wire logic                           clk,
    input  wire logic                           rstn,
    // instruction request
    input  wire logic                           start,
    input  wire cet_pkg::cet_form_t             form,
    input  wire logic [cet_pkg::CNT_W-1:0]      cnt_fetch,
    input  wire logic [cet_pkg::CNT_W-1:0]      cnt_branch,
    input  wire logic [cet_pkg::CNT_W-1:0]      cnt_stack,
    input  wire logic [cet_pkg::CNT_W-1:0]      cnt_byte,
    input  wire logic [cet_pkg::CNT_W-1:0]      cnt_word,
    input  wire logic [cet_pkg::CNT_W-1:0]      cnt_internal,
    // data access target
    input  wire logic                           data_to_peri,
    input  wire logic                           peri_slow,
    // status
    output logic                                busy,
    output logic [cet_pkg::NKIND-1:0]           cycle_kind,
    output logic                                cycle_first,
    output logic                                done,
    output logic [cet_pkg::TOTAL_W-1:0]         total_states,
    output logic [cet_pkg::TOTAL_W-1:0]         states_elapsed
);

    cet_timer_if tif ();

    cet_pkg::cet_state_t                state_reg;
    cet_pkg::cet_state_t                state_next;
    logic [cet_pkg::CNT_W-1:0]          rem_reg [cet_pkg::NKIND];
    logic [cet_pkg::CNT_W-1:0]          req_cnt [cet_pkg::NKIND];
    logic [cet_pkg::LEN_W-1:0]          cost    [cet_pkg::NKIND];
    logic [cet_pkg::LEN_W-1:0]          data_cost;
    logic                               peri_reg;
    logic                               slow_reg;
    logic [2:0]                         sel;
    logic                               any_left;
    logic                               take;
    logic                               issue;
    logic                               finish;
    logic [cet_pkg::TOTAL_W-1:0]        req_total;

    ////////////////////////////////////////////////////////////////////////
    // cycle counts from the instruction form
    assign req_cnt[cet_pkg::K_FETCH] =
        (form == cet_pkg::CET_FORM_CUSTOM)  ? cnt_fetch     :
        (form == cet_pkg::CET_FORM_REG_REG) ? cet_pkg::I_REG_REG :
        (form == cet_pkg::CET_FORM_IMM16)   ? cet_pkg::I_IMM16   :
        (form == cet_pkg::CET_FORM_IMM32)   ? cet_pkg::I_IMM32   :
        (form == cet_pkg::CET_FORM_BIT_MEM) ? cet_pkg::I_BIT_MEM :
        (form == cet_pkg::CET_FORM_SUB_JUMP) ? cet_pkg::I_SUB_JUMP : cet_pkg::I_BRA;
    assign req_cnt[cet_pkg::K_BRANCH] =
        (form == cet_pkg::CET_FORM_CUSTOM)  ? cnt_branch :
        (form == cet_pkg::CET_FORM_SUB_JUMP) ? cet_pkg::J_SUB_JUMP : cet_pkg::CNT_RST;
    assign req_cnt[cet_pkg::K_STACK] =
        (form == cet_pkg::CET_FORM_CUSTOM)  ? cnt_stack :
        (form == cet_pkg::CET_FORM_SUB_JUMP) ? cet_pkg::K_SUB_JUMP : cet_pkg::CNT_RST;
    assign req_cnt[cet_pkg::K_BYTE] =
        (form == cet_pkg::CET_FORM_CUSTOM)  ? cnt_byte :
        (form == cet_pkg::CET_FORM_BIT_MEM) ? cet_pkg::L_BIT_MEM : cet_pkg::CNT_RST;
    assign req_cnt[cet_pkg::K_WORD] =
        (form == cet_pkg::CET_FORM_CUSTOM)  ? cnt_word : cet_pkg::CNT_RST;
    assign req_cnt[cet_pkg::K_INTERNAL] =
        (form == cet_pkg::CET_FORM_CUSTOM)  ? cnt_internal :
        (form == cet_pkg::CET_FORM_BRA16)   ? cet_pkg::N_BRA16 : cet_pkg::CNT_RST;

    ////////////////////////////////////////////////////////////////////////
    // states per cycle kind; peripheral class is latched with the request
    // so a change on the pins mid-instruction cannot skew the count
    assign data_cost = (data_to_peri && peri_slow) ? cet_pkg::S_PERI_SLOW :
                       data_to_peri                ? cet_pkg::S_PERI_FAST :
                                                     cet_pkg::S_MEM;
    assign cost[cet_pkg::K_FETCH]    = cet_pkg::S_MEM;
    assign cost[cet_pkg::K_BRANCH]   = cet_pkg::S_MEM;
    assign cost[cet_pkg::K_STACK]    = cet_pkg::S_MEM;
    assign cost[cet_pkg::K_BYTE]     = !peri_reg ? cet_pkg::S_MEM :
                                       slow_reg  ? cet_pkg::S_PERI_SLOW :
                                                   cet_pkg::S_PERI_FAST;
    assign cost[cet_pkg::K_WORD]     = cost[cet_pkg::K_BYTE];
    assign cost[cet_pkg::K_INTERNAL] = cet_pkg::S_INTERNAL;

    ////////////////////////////////////////////////////////////////////////
    // expected total: each count times the states of its kind; both factors are
    // widened first, since a product left at three bits would wrap past seven
    assign req_total =
          cet_pkg::TOTAL_W'(req_cnt[cet_pkg::K_FETCH])    * cet_pkg::TOTAL_W'(cet_pkg::S_MEM)
        + cet_pkg::TOTAL_W'(req_cnt[cet_pkg::K_BRANCH])   * cet_pkg::TOTAL_W'(cet_pkg::S_MEM)
        + cet_pkg::TOTAL_W'(req_cnt[cet_pkg::K_STACK])    * cet_pkg::TOTAL_W'(cet_pkg::S_MEM)
        + cet_pkg::TOTAL_W'(req_cnt[cet_pkg::K_BYTE])     * cet_pkg::TOTAL_W'(data_cost)
        + cet_pkg::TOTAL_W'(req_cnt[cet_pkg::K_WORD])     * cet_pkg::TOTAL_W'(data_cost)
        + cet_pkg::TOTAL_W'(req_cnt[cet_pkg::K_INTERNAL]) * cet_pkg::TOTAL_W'(cet_pkg::S_INTERNAL);

    ////////////////////////////////////////////////////////////////////////
    // next kind to run: lowest kind with cycles left
    // scanning from the top down leaves the lowest such kind in sel
    always_comb
    begin
        sel      = 3'h0;
        any_left = 1'b0;
        for (int k = cet_pkg::NKIND - 1; k >= 0; k--)
        begin
            if (rem_reg[k] != cet_pkg::CNT_RST)
            begin
                sel      = 3'(k);
                any_left = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencing decode
    assign take     = (state_reg == cet_pkg::CET_IDLE) && start;
    assign issue    = (state_reg == cet_pkg::CET_RUN) && any_left
                      && (!tif.active || tif.last);
    assign finish   = (state_reg == cet_pkg::CET_RUN) && !any_left
                      && (!tif.active || tif.last);
    assign tif.load = issue;
    assign tif.len  = cost[sel];

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            cet_pkg::CET_IDLE: if (take)   state_next = cet_pkg::CET_RUN;
            cet_pkg::CET_RUN:  if (finish) state_next = cet_pkg::CET_IDLE;
            default:           state_next = cet_pkg::CET_IDLE;
        endcase
    end

    // the timer owns the state count of the cycle in flight
    cet_state_timer u_timer
    (
        .clk    (clk),
        .rstn   (rstn),
        .tif    (tif)
    );

    ////////////////////////////////////////////////////////////////////////
    // cycles left per kind: loaded on request, one off per issued cycle
    always_ff @(posedge clk)
    begin
        for (int k = 0; k < cet_pkg::NKIND; k++)
        begin
            if (!rstn)
                rem_reg[k] <= cet_pkg::CNT_RST;
            else if (take)
                rem_reg[k] <= req_cnt[k];
            else if (issue && (sel == 3'(k)))
                rem_reg[k] <= rem_reg[k] - cet_pkg::CNT_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer state and latched access class
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            state_reg <= cet_pkg::CET_IDLE;
            peri_reg  <= 1'b0;
            slow_reg  <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            if (take)
            begin
                peri_reg <= data_to_peri;
                slow_reg <= peri_slow;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registered status outputs
    // busy follows the next state, so it falls at the same edge as done rises
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            busy           <= 1'b0;
            cycle_kind     <= cet_pkg::KIND_RST;
            cycle_first    <= 1'b0;
            done           <= 1'b0;
            total_states   <= cet_pkg::TOTAL_RST;
            states_elapsed <= cet_pkg::TOTAL_RST;
        end
        else
        begin
            busy        <= (state_next == cet_pkg::CET_RUN);
            cycle_first <= issue;
            done        <= finish;
            if (take)
                total_states <= req_total;
            if (issue)
                cycle_kind <= cet_pkg::NKIND'(1) << sel;
            else if (tif.last || finish)
                cycle_kind <= cet_pkg::KIND_RST;
            if (take)
                states_elapsed <= cet_pkg::TOTAL_RST;
            else if (issue || tif.active && !tif.last)
                states_elapsed <= states_elapsed + cet_pkg::TOTAL_W'(1);
            else if (tif.last)
                states_elapsed <= states_elapsed;
        end
    end

endmodule // cet_exec_timing

// ### design/cet_pkg.sv
/*
 * cet_pkg: constants and types shared by the execution state timing block.
 * Assumes the instruction decoder outside presents one instruction form
 * (or explicit cycle counts) per start request.
 */
package cet_pkg;

    // cycle kinds, in the order the core walks them
    localparam int NKIND      = 6;
    localparam int K_FETCH    = 0;
    localparam int K_BRANCH   = 1;
    localparam int K_STACK    = 2;
    localparam int K_BYTE     = 3;
    localparam int K_WORD     = 4;
    localparam int K_INTERNAL = 5;

    // widths
    localparam int CNT_W   = 3;   // per-kind cycle count
    localparam int LEN_W   = 2;   // states of one cycle
    localparam int TOTAL_W = 8;   // states of one instruction

    // states each cycle costs
    localparam logic [LEN_W-1:0] S_MEM       = 2'h2;
    localparam logic [LEN_W-1:0] S_PERI_FAST = 2'h2;
    localparam logic [LEN_W-1:0] S_PERI_SLOW = 2'h3;
    localparam logic [LEN_W-1:0] S_INTERNAL  = 2'h1;

    // values after reset
    localparam logic [TOTAL_W-1:0] TOTAL_RST = 8'h00;
    localparam logic [CNT_W-1:0]   CNT_RST   = 3'h0;
    localparam logic [NKIND-1:0]   KIND_RST  = 6'h00;

    // instruction forms; all but CET_FORM_CUSTOM have fixed cycle counts
    typedef enum logic [2:0] {
        CET_FORM_CUSTOM  = 3'h0,  // counts taken from the count inputs
        CET_FORM_REG_REG = 3'h1,
        CET_FORM_IMM16   = 3'h2,
        CET_FORM_IMM32   = 3'h3,
        CET_FORM_BRA8    = 3'h4,
        CET_FORM_BRA16   = 3'h5,
        CET_FORM_BIT_MEM = 3'h6,  // bit_set_op and kin on memory
        CET_FORM_SUB_JUMP = 3'h7  // subroutine_jump_op through a vector
    } cet_form_t;

    // cycle counts per form
    localparam logic [CNT_W-1:0] I_REG_REG = 3'h1;
    localparam logic [CNT_W-1:0] I_IMM16   = 3'h2;
    localparam logic [CNT_W-1:0] I_IMM32   = 3'h3;
    localparam logic [CNT_W-1:0] I_BRA     = 3'h2;
    localparam logic [CNT_W-1:0] N_BRA16   = 3'h2;
    localparam logic [CNT_W-1:0] I_BIT_MEM = 3'h2;
    localparam logic [CNT_W-1:0] L_BIT_MEM = 3'h2;
    localparam logic [CNT_W-1:0] I_SUB_JUMP = 3'h2;
    localparam logic [CNT_W-1:0] J_SUB_JUMP = 3'h1;
    localparam logic [CNT_W-1:0] K_SUB_JUMP = 3'h1;

    // sequencer states, one-hot
    typedef enum logic [1:0] {
        CET_IDLE = 2'b01,
        CET_RUN  = 2'b10
    } cet_state_t;

endpackage

// ### design/cet_timer_if.sv
/*
 * cet_timer_if: link between the sequencer and its state timer.
 * Assumes both ends share clk and rstn of the top module.
 */
`timescale 1ns/1ps
interface cet_timer_if;
    logic                       load;   // start a cycle this clock
    logic [cet_pkg::LEN_W-1:0]  len;    // states of that cycle
    logic                       active; // a cycle is in progress
    logic                       last;   // final state of the cycle

    modport seq (output load, output len, input active, input last);
    modport tmr (input load, input len, output active, output last);
endinterface

// ### design/cet_state_timer.sv
/*
 * cet_state_timer: counts the states of one bus or internal cycle.
 * Assumes a load arrives only when idle or in the final state.
 */
`timescale 1ns/1ps
module cet_state_timer
(
    // clock and reset
    input  wire logic   clk,
    input  wire logic   rstn,
    // sequencer side
    cet_timer_if.tmr    tif
);

    logic [cet_pkg::LEN_W-1:0] left_reg;
    logic [cet_pkg::LEN_W-1:0] left_next;

    ////////////////////////////////////////////////////////////////////////
    // status decode
    assign tif.active = (left_reg != '0);
    assign tif.last   = (left_reg == cet_pkg::LEN_W'(1));

    // a reload in the last state chains cycles with no idle gap
    assign left_next  = tif.load   ? tif.len :
                        tif.active ? left_reg - cet_pkg::LEN_W'(1) : left_reg;

    ////////////////////////////////////////////////////////////////////////
    // states left in the current cycle
    always_ff @(posedge clk)
    begin
        if (!rstn)
            left_reg <= '0;
        else
            left_reg <= left_next;
    end

endmodule // cet_state_timer

// ### sim/cet_periph_model.sv
/* cet_periph_model: stand-in for on-chip memory and peripheral modules on the internal bus.
   assumes the bench picks one data target for each instruction. */
`timescale 1ns/1ps
module cet_periph_model
(
    // target: 0 memory, 1 quick module, 2 and 3 slow modules
    input  wire logic [1:0] sel,
    // wait class handed to the core
    output logic            data_to_peri,
    output logic            peri_slow
);
    // code and stack always sit in memory, so only data accesses can reach a module
    assign data_to_peri = (sel != 2'h0);
    assign peri_slow    = sel[1];
endmodule // cet_periph_model

// ### sim/cet_exec_timing_properties.sv
/* cet_exec_timing_properties: timing relations of the state sequencer at its ports.
   assumes one clock and the synchronous active-low reset of the top module. */
`timescale 1ns/1ps
module cet_exec_timing_properties
(
    // clock and reset
    input wire logic                        clk,
    input wire logic                        rstn,
    // request
    input wire logic                        start,
    input wire logic                        data_to_peri,
    input wire logic                        peri_slow,
    // status
    input wire logic                        busy,
    input wire logic [cet_pkg::NKIND-1:0]   cycle_kind,
    input wire logic                        cycle_first,
    input wire logic                        done,
    input wire logic [cet_pkg::TOTAL_W-1:0] total_states,
    input wire logic [cet_pkg::TOTAL_W-1:0] states_elapsed
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////////////
    // wait class caught with the accepted start; a start while busy must not move it
    logic slow_reg;
    logic slow_next;
    assign slow_next = (start && !busy) ? (data_to_peri && peri_slow) : slow_reg;
    always_ff @(posedge clk) slow_reg <= rstn ? slow_next : 1'b0;
    ////////////////////////////////////////////////////////////////////////////////
    // totals and ordering
    done_total_a: assert property (done |-> states_elapsed == total_states)
        else $error("elapsed count differs from total at done");
    total_hold_a: assert property (busy && $past(busy)
        |-> $stable(total_states)) else $error("total changed during an instruction");
    start_busy_a: assert property (start && !busy |=> busy)
        else $error("accepted start did not raise busy");
    done_idle_a: assert property (done |-> !busy && cycle_kind == 6'h00)
        else $error("done while busy or a cycle kind shown");
    kind_order_a: assert property ($changed(cycle_kind) && cycle_kind != 6'h00
        && $past(cycle_kind) != 6'h00 |-> cycle_kind > $past(cycle_kind))
        else $error("cycle kinds walked out of order");
    first_change_a: assert property ($changed(cycle_kind) && cycle_kind != 6'h00
        |-> cycle_first && $onehot(cycle_kind)) else $error("kind change without first state");
    // length of each cycle kind in states
    fetch_len_a: assert property (cycle_first && cycle_kind[0]
        |=> !cycle_first ##1 (cycle_first || done)) else $error("fetch not two states");
    branch_stack_a: assert property (cycle_first
        && (cycle_kind[1] || cycle_kind[2]) |=> !cycle_first ##1 (cycle_first || done))
        else $error("branch or stack not two states");
    data_quick_a: assert property (cycle_first
        && (cycle_kind[3] || cycle_kind[4]) && !slow_reg
        |=> !cycle_first ##1 (cycle_first || done))
        else $error("quick data access not two states");
    data_slow_a: assert property (cycle_first
        && (cycle_kind[3] || cycle_kind[4]) && slow_reg
        |=> !cycle_first [*2] ##1 (cycle_first || done))
        else $error("slow data access not three states");
    internal_len_a: assert property (cycle_first && cycle_kind[5]
        |=> cycle_first || done) else $error("internal cycle not one state");
    // main scenarios
    cover property (done && total_states == 8'h08);
    cover property (cycle_first && cycle_kind[4] && slow_reg);
    cover property (start && busy);
    cover property (cycle_first && cycle_kind[5]);
endmodule // cet_exec_timing_properties
bind cet_exec_timing cet_exec_timing_properties i_cet_exec_timing_properties (.clk(clk),
    .rstn(rstn), .start(start), .data_to_peri(data_to_peri), .peri_slow(peri_slow), .busy(busy),
    .cycle_kind(cycle_kind), .cycle_first(cycle_first), .done(done),
    .total_states(total_states), .states_elapsed(states_elapsed));

// ### sim/cet_exec_timing_tb_top.sv
/* cet_exec_timing_tb_top: integer model of the state count, compared at every instruction.
   assumes the package, the design, the target model and the checker compile first. */
`timescale 1ns/1ps
module cet_exec_timing_tb_top;
    logic                        clk = 1'b0;
    logic                        rstn = 1'b0;
    logic                        start = 1'b0;
    cet_pkg::cet_form_t          form = cet_pkg::CET_FORM_CUSTOM;
    logic [cet_pkg::CNT_W-1:0]   cnt [6] = '{default: 3'h0};
    logic [1:0]                  sel = 2'h0;
    logic                        data_to_peri, peri_slow, busy, cycle_first, done;
    logic [cet_pkg::NKIND-1:0]   cycle_kind;
    logic [cet_pkg::TOTAL_W-1:0] total_states, states_elapsed;
    int                          fails = 0, total_checks = 0, cycles = 0, seed = 32'h3357;
    int                          zc [6] = '{default: 0};
    cet_periph_model i_cet_periph_model (.sel(sel), .data_to_peri(data_to_peri),
        .peri_slow(peri_slow));
    cet_exec_timing i_cet_exec_timing (.clk(clk), .rstn(rstn), .start(start), .form(form),
        .cnt_fetch(cnt[0]), .cnt_branch(cnt[1]), .cnt_stack(cnt[2]), .cnt_byte(cnt[3]),
        .cnt_word(cnt[4]), .cnt_internal(cnt[5]), .data_to_peri(data_to_peri),
        .peri_slow(peri_slow), .busy(busy), .cycle_kind(cycle_kind),
        .cycle_first(cycle_first), .done(done), .total_states(total_states),
        .states_elapsed(states_elapsed));
    ////////////////////////////////////////////////////////////////////////////////
    // clock and hang guard; the ceiling is more than six times the longest sequence the bench can run
    always #2 clk = ~clk;
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            close_out();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // states one cycle of kind b costs for data target s
    function automatic int cost(input int b, input int s);
        return (b == 5) ? 1 : (b > 2 && s > 1) ? 3 : 2;
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    // one instruction: driven at a falling edge, every state tallied until done
    task automatic run(input int f, input int s, input int c [6], input bit rej);
        int ec [6] = '{default: 0};
        int st [6] = '{default: 0};
        int fi [6] = '{default: 0};
        int q [$];
        int tot = 0;
        int k = 0;
        case (f)
            1: ec[0] = 1;
            2: ec[0] = 2;
            3: ec[0] = 3;
            4: ec[0] = 2;
            5: ec = '{2, 0, 0, 0, 0, 2};
            6: ec = '{2, 0, 0, 2, 0, 0};
            7: ec = '{2, 1, 1, 0, 0, 0};
            default: ec = c;
        endcase
        // expected order of cycles: all fetches, then branch, stack, byte, word, internal
        for (int b = 0; b < 6; b++)
        begin
            tot += ec[b] * cost(b, s);
            for (int n = 0; n < ec[b]; n++)
                q.push_back(b);
        end
        start = 1'b1;
        form = cet_pkg::cet_form_t'(f);
        sel = 2'(s);
        for (int b = 0; b < 6; b++)
            cnt[b] = 3'(c[b]);
        while (k < 300 && (k == 0 || done !== 1'b1))
        begin
            @(negedge clk);
            k++;
            if (k == 1)
                start = 1'b0;
            // a second request, new form and target, must leave the count alone
            if (rej && k == 3)
            begin
                start = 1'b1;
                form = cet_pkg::CET_FORM_REG_REG;
                sel = 2'h0;
            end
            if (rej && k == 4)
                start = 1'b0;
            if (k == 1)
                check(8'(busy), 8'h01);
            if (k == 1)
                check(total_states, 8'(tot));
            if (cycle_first === 1'b1 && q.size() > 0)
                check(8'(cycle_kind), 8'(1 << q.pop_front()));
            for (int b = 0; b < 6; b++)
                if (cycle_kind[b] === 1'b1)
                begin
                    st[b]++;
                    fi[b] += (cycle_first === 1'b1);
                end
        end
        check(8'(k), 8'(tot + 2));
        check(states_elapsed, 8'(tot));
        check(8'(busy), 8'h00);
        for (int b = 0; b < 6; b++)
        begin
            check(8'(st[b]), 8'(ec[b] * cost(b, s)));
            check(8'(fi[b]), 8'(ec[b]));
        end
        $display("test form %0d target %0d ended", f, s);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence; each run starts in the done cycle of the one before, except the first and last, which start in the first cycle after reset release
    initial
    begin
        int c [6];
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        for (int f = 1; f < 8; f++)
            for (int s = 0; s < 4; s++)
                run(f, s, zc, 1'b0);
        run(0, 0, zc, 1'b0);
        run(0, 3, '{7, 7, 7, 7, 7, 7}, 1'b1);
        repeat (30)
        begin
            for (int b = 0; b < 6; b++)
                c[b] = $random(seed) & 7;
            run(0, $random(seed) & 3, c, 1'b0);
        end
        // reset in mid-instruction, then a start in the first cycle after release
        form = cet_pkg::CET_FORM_IMM32;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        repeat (4) @(negedge clk);
        rstn = 1'b0;
        repeat (2) @(negedge clk);
        check(8'(busy), 8'h00);
        check(total_states, 8'h00);
        check(8'(cycle_kind), 8'h00);
        check(states_elapsed, 8'h00);
        check(8'(done), 8'h00);
        $display("test reset in mid-instruction ended");
        rstn = 1'b1;
        run(6, 2, zc, 1'b0);
        close_out();
    end
endmodule // cet_exec_timing_tb_top
